// ===== hdl/modstream_host.sv
`timescale 1ns/1ps
`default_nettype none
module modstream_host #(
    parameter int DIV = 250,
    parameter int LEN = modstream_pkg::WINDOW_LEN,
    parameter int SETTLE = modstream_pkg::SETTLE_LEN
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // link
    modstream_if.host link,
    // user control
    input wire logic start_i,
    input wire logic bias_en_i,
    // results
    output logic [modstream_pkg::CNT_W-1:0] offset_o,
    output logic [modstream_pkg::CNT_W-1:0] gain_o,
    output logic [modstream_pkg::CNT_W-1:0] meas_o,
    output logic valid_o
);
    import modstream_pkg::*;
    phase_t ph_reg, ph_next;
    logic [15:0] div_reg;
    logic mclk_reg, gsel_reg, caln_reg, bias_reg;
    logic s1_reg, s2_reg;
    logic [CNT_W-1:0] settle_reg;
    logic win_start;
    logic [CNT_W-1:0] count;
    logic done;
    logic busy_reg;
    // fixed 50 % divider for the modulator clock
    wire half = (div_reg == 16'(DIV/2 - 1));
    wire fall = half && mclk_reg; // falling edge about to occur
    always_ff @(posedge clk_i) begin
        if (reset_i || half) div_reg <= '0;
        else div_reg <= div_reg + 16'h0001;
        if (reset_i) mclk_reg <= 1'b0;
        else if (half) mclk_reg <= !mclk_reg;
    end
    // stream synchroniser; sampled at the falling edge
    always_ff @(posedge clk_i) begin
        s1_reg <= link.bitstream_out;
        s2_reg <= s1_reg;
    end
    wire settled = (settle_reg == '0);
    // settle counter restarts on each mode change
    always_ff @(posedge clk_i) begin
        if (reset_i || ph_reg != ph_next) settle_reg <= CNT_W'(SETTLE);
        else if (fall && !settled) settle_reg <= settle_reg - 1'b1;
    end
    // a window opens only in a counting phase, once settled
    assign win_start = fall && settled && !busy_reg;
    wire win_go = win_start && ph_reg != PH_IDLE && ph_reg != PH_DONE;
    always_ff @(posedge clk_i) begin
        if (reset_i || done) busy_reg <= 1'b0;
        else if (win_go) busy_reg <= 1'b1;
    end
    ones_window #(.LEN(LEN), .W(CNT_W)) ones_window_i (
        .clk_i(clk_i), .reset_i(reset_i),
        .start_i(win_go),
        .sample_i(fall), .bit_i(s2_reg),
        .count_o(count), .done_o(done));
    // phase order: offset, gain, then normal measurement
    always_comb begin
        ph_next = ph_reg;
        unique case (ph_reg)
            PH_IDLE: if (start_i) ph_next = PH_OFFSET;
            PH_OFFSET: if (done) ph_next = PH_GAIN;
            PH_GAIN: if (done) ph_next = PH_MEASURE;
            PH_MEASURE: if (done) ph_next = PH_DONE;
            PH_DONE: ph_next = PH_MEASURE;
            default: ph_next = PH_IDLE;
        endcase
    end
    // mode pins held steady for the whole phase
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ph_reg <= PH_IDLE;
            gsel_reg <= SEL_OFFSET;
            caln_reg <= !CAL_ACTIVE_N;
            bias_reg <= 1'b0;
        end else begin
            ph_reg <= ph_next;
            gsel_reg <= (ph_next == PH_GAIN) ? SEL_GAIN : SEL_OFFSET;
            caln_reg <= (ph_next == PH_OFFSET || ph_next == PH_GAIN) ?
                CAL_ACTIVE_N : !CAL_ACTIVE_N;
            bias_reg <= bias_en_i;
        end
    end
    // store offset and gain counts, latch each measurement
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            offset_o <= '0;
            gain_o <= '0;
            meas_o <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= done && ph_reg == PH_MEASURE;
            if (done && ph_reg == PH_OFFSET) offset_o <= count;
            if (done && ph_reg == PH_GAIN) gain_o <= count;
            if (done && ph_reg == PH_MEASURE) meas_o <= count;
        end
    end
    assign link.mod_clk = mclk_reg;
    assign link.gain_sel = gsel_reg;
    assign link.cal_en_n = caln_reg;
    assign link.bias_en = bias_reg;
endmodule // modstream_host
`default_nettype wire

// ===== hdl/modstream_pkg.sv
package modstream_pkg;
    // width of the digital stand-in for a differential input sample
    localparam int IN_W = 16;
    // mode pin encodings
    localparam logic SEL_OFFSET = 1'b0;
    localparam logic SEL_GAIN = 1'b1;
    localparam logic CAL_ACTIVE_N = 1'b0;
    // input codes seen by the loop in calibration modes
    localparam logic signed [15:0] IN_ZERO = 16'sh0000;
    localparam logic signed [15:0] IN_FULL = 16'sh7fff;
    // loop feedback levels: ones density spans 10 % .. 90 %
    localparam logic signed [23:0] FB_HIGH = 24'sh00_9ffe;
    localparam logic signed [23:0] FB_LOW = -24'sh00_9ffe;
    // counting window length in modulator clock periods
    localparam int WINDOW_LEN = 1024;
    localparam int SETTLE_LEN = 64;
    localparam int CNT_W = 12;
    // host sequencer phases
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_OFFSET = 5'b00010,
        PH_GAIN = 5'b00100,
        PH_MEASURE = 5'b01000,
        PH_DONE = 5'b10000
    } phase_t;
endpackage

// ===== hdl/modstream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface modstream_if;
    logic mod_clk;
    logic bitstream_out;
    logic gain_sel;
    logic cal_en_n;
    logic bias_en;
    modport device (input mod_clk, gain_sel, cal_en_n, bias_en,
        output bitstream_out);
    modport host (output mod_clk, gain_sel, cal_en_n, bias_en,
        input bitstream_out);
endinterface
`default_nettype wire

// ===== hdl/ones_window.sv
`timescale 1ns/1ps
`default_nettype none
module ones_window #(
    parameter int LEN = modstream_pkg::WINDOW_LEN,
    parameter int W = modstream_pkg::CNT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control and stream
    input wire logic start_i,
    input wire logic sample_i,
    input wire logic bit_i,
    // result
    output logic [W-1:0] count_o,
    output logic done_o
);
    import modstream_pkg::*;
    logic [W-1:0] left_reg;
    logic [W-1:0] ones_reg;
    logic busy_reg;
    wire last = busy_reg && sample_i && (left_reg == W'(1));
    // count ones over exactly LEN sampled periods
    always_ff @(posedge clk_i) begin
        if (reset_i || start_i) begin
            left_reg <= W'(LEN);
            ones_reg <= '0;
            busy_reg <= start_i && !reset_i;
        end else if (busy_reg && sample_i) begin
            left_reg <= left_reg - W'(1);
            ones_reg <= ones_reg + W'(bit_i);
            if (last) begin
                busy_reg <= 1'b0;
            end
        end
    end
    // latch result at window end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            count_o <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= last;
            if (last) begin
                count_o <= ones_reg + W'(bit_i);
            end
        end
    end
endmodule // ones_window
`default_nettype wire

// ===== hdl/modstream_device.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - modulator clock is sole clock, one bit/period
// - result leaves as continuous serial bit stream
// - host samples stream on falling clock edge
// - host keeps clock duty cycle constant
// - zero input gives half ones
// - full scale gives ninety or ten percent
// - select 0, enable 1 means normal sampling
// - select 0, enable 0 shorts inputs: offset
// - select 1, enable 0 uses reference: gain
// - calibration modes keep producing the stream
// - host calibrates offset first, then gain
// - host calibrates once, then resumes normal
// - host recalibrates after power-on, drift (here: once per reset, start ignored after)
// - host corrects with stored offset, gain (here: both stored, meas_o left as the raw count)
// - host counts ones over equal windows
// - system calibration uses two known voltages
// - bias output driven when enabled, else released
// - host keeps clock within supported range
module modstream_device (
    // link
    modstream_if.device link,
    // user side: digital stand-in for the analog inputs
    input wire logic signed [modstream_pkg::IN_W-1:0] analog_in_pos,
    input wire logic signed [modstream_pkg::IN_W-1:0] analog_in_neg,
    // bias output as two signals
    output logic bias_out_o,
    output logic bias_oe_o
);
    import modstream_pkg::*;
    // no reset pin: loop and bias start from zero at power-up
    logic signed [23:0] integ1_reg = '0;
    logic signed [23:0] integ2_reg = '0;
    logic bit_reg = 1'b0;
    logic bias_reg = 1'b0;
    wire cal_on = (link.cal_en_n == CAL_ACTIVE_N);
    wire signed [IN_W:0] diff_in =
        (IN_W+1)'(analog_in_pos) - (IN_W+1)'(analog_in_neg);
    // shorted inputs or reference replace the analog input
    wire signed [IN_W:0] loop_in =
        !cal_on ? diff_in :
        (link.gain_sel == SEL_GAIN) ? (IN_W+1)'(IN_FULL) :
        (IN_W+1)'(IN_ZERO);
    // 1-bit dac feedback, symmetric so zero gives 50 %
    wire signed [23:0] fb = bit_reg ? FB_HIGH : FB_LOW;
    wire signed [23:0] int1_next = integ1_reg + 24'(loop_in) - fb;
    wire signed [23:0] int2_next = integ2_reg + int1_next - fb;
    // second-order loop, one result per modulator clock
    always_ff @(posedge link.mod_clk) begin
        integ1_reg <= int1_next;
        integ2_reg <= int2_next;
        bit_reg <= !int2_next[23];
    end
    // bias enable follows the pin each period
    always_ff @(posedge link.mod_clk) begin
        bias_reg <= link.bias_en;
    end
    // stream pin, stable across the falling edge
    assign link.bitstream_out = bit_reg;
    assign bias_out_o = bias_reg;
    assign bias_oe_o = bias_reg;
endmodule // modstream_device
`default_nettype wire

// ===== dv/modstream_checker.sv
`timescale 1ns/1ps
`default_nettype none
module modstream_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // link and bias pins
    input wire logic mod_clk,
    input wire logic bitstream_out,
    input wire logic gain_sel,
    input wire logic cal_en_n,
    input wire logic bias_en,
    input wire logic bias_out_o,
    input wire logic bias_oe_o
);
    logic cal_done_reg;
    logic [7:0] still_reg;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // end of calibration seen, clocks since stream last toggled
    always_ff @(posedge clk_i) begin
        cal_done_reg <= !reset_i && (cal_done_reg || $rose(cal_en_n));
        still_reg <= $changed(bitstream_out) ? 8'h00 : still_reg + 8'h01;
    end
    a_stream_on_rise: assert property (
        $changed(bitstream_out) |-> $rose(mod_clk))
        else $error("stream moved off a clock rise");
    a_clock_duty: assert property (
        $rose(mod_clk) |-> mod_clk[*4] ##1 !mod_clk[*4] ##1 mod_clk)
        else $error("modulator clock duty broken");
    a_mode_legal: assert property (!(gain_sel && cal_en_n))
        else $error("undefined mode pin pair");
    a_offset_first: assert property (
        $fell(cal_en_n) |-> !gain_sel)
        else $error("calibration began without offset");
    a_gain_after: assert property (
        $rose(gain_sel) |-> !cal_en_n && !$past(cal_en_n))
        else $error("gain phase not after offset");
    a_cal_once: assert property (cal_done_reg |-> cal_en_n)
        else $error("calibration entered again");
    a_stream_alive: assert property (
        !cal_en_n |-> still_reg < 8'hc8)
        else $error("stream stuck in calibration");
    a_bias_on: assert property (
        bias_en && !bias_oe_o |-> ##[1:12] bias_oe_o && bias_out_o)
        else $error("bias not driven");
    a_bias_off: assert property (
        !bias_en && bias_oe_o |-> ##[1:12] !bias_oe_o)
        else $error("bias not released");
    // main scenarios reached
    cover property ($rose(gain_sel));
    cover property ($rose(cal_en_n));
    cover property ($rose(bias_oe_o));
endmodule // modstream_checker
`default_nettype wire

// ===== dv/modulator_stream_calibration_test.sv
`timescale 1ns/1ps
`default_nettype none
module modulator_stream_calibration_test;
    import modstream_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic bias_en_i = 1'b0;
    logic signed [IN_W-1:0] in_pos = IN_ZERO;
    logic signed [IN_W-1:0] in_neg = IN_ZERO;
    logic bias_out_o, bias_oe_o, valid_o;
    logic [CNT_W-1:0] offset_o, gain_o, meas_o;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    modstream_if modstream_if_i ();
    modstream_device modstream_device_i (.link(modstream_if_i),
        .analog_in_pos(in_pos), .analog_in_neg(in_neg),
        .bias_out_o(bias_out_o), .bias_oe_o(bias_oe_o));
    modstream_host #(.DIV(8), .LEN(32), .SETTLE(4)) modstream_host_i (
        .clk_i(clk_i), .reset_i(reset_i), .link(modstream_if_i),
        .start_i(start_i), .bias_en_i(bias_en_i), .offset_o(offset_o),
        .gain_o(gain_o), .meas_o(meas_o), .valid_o(valid_o));
    modstream_checker modstream_checker_i (.clk_i(clk_i),
        .reset_i(reset_i), .mod_clk(modstream_if_i.mod_clk),
        .bitstream_out(modstream_if_i.bitstream_out),
        .gain_sel(modstream_if_i.gain_sel),
        .cal_en_n(modstream_if_i.cal_en_n),
        .bias_en(modstream_if_i.bias_en),
        .bias_out_o(bias_out_o), .bias_oe_o(bias_oe_o));
    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // count within three of the ideal density
    function automatic logic [11:0] near(logic [11:0] v, int e);
        return 12'((v >= e - 3) && (v <= e + 3));
    endfunction
    task automatic wait_valid();
        for (int n = 0; n < 3000; n++) begin
            @(posedge clk_i);
            #1;
            if (valid_o === 1'b1) return;
        end
        check("valid_o", 12'h000, 12'h001);
    endtask
    task automatic pulse_start();
        start_i = 1'b1;
        @(posedge clk_i);
        #1 start_i = 1'b0;
    endtask
    task automatic test_bias();
        bias_en_i = 1'b1;
        repeat (20) @(posedge clk_i);
        #1 check("bias_oe_o on", 12'(bias_oe_o), 12'h001);
        check("bias_out_o", 12'(bias_out_o), 12'h001);
        bias_en_i = 1'b0;
        repeat (20) @(posedge clk_i);
        #1 check("bias_oe_o off", 12'(bias_oe_o), 12'h000);
        $display("test_bias done");
    endtask
    task automatic test_cal();
        // negative full input: calibration must not see it
        in_neg = IN_FULL;
        pulse_start();
        wait_valid();
        check("offset_o", near(offset_o, 16), 12'h001);
        check("gain_o", near(gain_o, 29), 12'h001);
        check("meas_o neg", near(meas_o, 3), 12'h001);
        $display("test_cal done");
    endtask
    task automatic test_meas();
        logic signed [15:0] pos [3] = '{IN_FULL, IN_ZERO, IN_ZERO};
        logic signed [15:0] neg [3] = '{IN_ZERO, IN_FULL, IN_ZERO};
        int exp [3] = '{29, 3, 16};
        for (int k = 0; k < 3; k++) begin
            in_pos = pos[k];
            in_neg = neg[k];
            wait_valid();
            wait_valid();
            check("meas_o", near(meas_o, exp[k]), 12'h001);
        end
        $display("test_meas done");
    endtask
    task automatic test_refuse();
        pulse_start();
        repeat (2) @(posedge clk_i);
        #1 check("cal_en_n", 12'(modstream_if_i.cal_en_n), 12'h001);
        wait_valid();
        check("meas_o again", near(meas_o, 16), 12'h001);
        $display("test_refuse done");
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        #1 reset_i = 1'b0;
        test_bias();
        test_cal();
        test_meas();
        test_refuse();
        give_verdict();
    end
endmodule // modulator_stream_calibration_test
`default_nettype wire
